// file: tlb_support_pkg.sv
// Package of register indices, field layouts and constants for the translation support registers
package tlb_support_pkg;

  // ****************************************
  // Register indices
  // ****************************************
  localparam logic [4:0] REG_CONTEXT_POINTER = 5'h04;
  localparam logic [4:0] REG_PAGE_SIZE_MASK  = 5'h05;
  localparam logic [4:0] REG_FIXED_BOUNDARY  = 5'h06;
  localparam logic [4:0] REG_RANDOM_INDEX    = 5'h01;
  localparam logic [4:0] REG_FAULT_ADDRESS   = 5'h08;
  localparam logic [4:0] REG_TIMER_COUNTER   = 5'h09;
  localparam logic [4:0] REG_ENTRY_HIGH      = 5'h0a;
  localparam logic [4:0] REG_TIMER_MATCH     = 5'h0b;

  // ****************************************
  // Field layouts
  // ****************************************
  localparam int CTX_PAIR_LSB      = 4;
  localparam int CTX_PAIR_MSB      = 22;
  localparam int CTX_BASE_LSB      = 23;
  localparam int VA_PAIR_LSB       = 13;
  localparam int VA_PAIR32_MSB     = 31;
  localparam int MASK_LSB          = 13;
  localparam int MASK_MSB          = 24;
  localparam int MASK_WIDTH        = 12;
  localparam int ENTRY_TAG_MSB     = 7;
  localparam int ENTRY_PAIR_LSB    = 13;
  localparam int ENTRY_PAIR_MSB    = 43;
  localparam int ENTRY_REGION_LSB  = 62;
  localparam int ENTRY_REGION_MSB  = 63;
  localparam int LOW_HALF_MSB      = 31;
  localparam int TIMER_PENDING_BIT = 7;
  localparam int TIMER_MASK_BIT    = 7;

  // ****************************************
  // Legal page size masks
  // ****************************************
  localparam logic [11:0] MASK_4K   = 12'h000;
  localparam logic [11:0] MASK_16K  = 12'h003;
  localparam logic [11:0] MASK_64K  = 12'h00f;
  localparam logic [11:0] MASK_256K = 12'h03f;
  localparam logic [11:0] MASK_1M   = 12'h0ff;
  localparam logic [11:0] MASK_4M   = 12'h3ff;
  localparam logic [11:0] MASK_16M  = 12'hfff;

  // ****************************************
  // Reset values and constants
  // ****************************************
  localparam logic [31:0] BOUNDARY_RESET = 32'h0000_0000;
  localparam logic [63:0] ZERO64         = 64'h0000_0000_0000_0000;
  localparam logic [31:0] TIMER_STEP     = 32'h0000_0001;
  localparam int          TLB_ENTRIES    = 64;

  typedef enum logic [1:0] {
    REGION_USER       = 2'h0,
    REGION_SUPERVISOR = 2'h1,
    REGION_KERNEL     = 2'h3
  } region_t;

endpackage : tlb_support_pkg

// file: timer_match_unit.sv
// Free-running timer with compare match and pending flag
`timescale 1ns/100ps
module timer_match_unit (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        count_write,
  input  wire logic        match_write,
  input  wire logic [31:0] write_data,
  output logic [31:0]      count_value,
  output logic [31:0]      match_value,
  output logic             pending
);

  logic half_rate;
  logic next_pending;

  // ****************************************
  // Divider for the half-rate increment
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      half_rate <= 1'b0;
    end else begin
      half_rate <= ~half_rate;
    end
  end

  // ****************************************
  // Counter and compare value
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_value <= 32'h0000_0000;
    end else if (count_write) begin
      count_value <= write_data;
    end else if (half_rate) begin
      count_value <= count_value + tlb_support_pkg::TIMER_STEP;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      match_value <= 32'hffff_ffff;
    end else if (match_write) begin
      match_value <= write_data;
    end
  end

  // Clear by compare write wins only if no match is present in the same cycle
  always_comb begin
    next_pending = pending;
    if (match_write) begin
      next_pending = 1'b0;
    end
    if (count_value == match_value) begin
      next_pending = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending <= 1'b0;
    end else begin
      pending <= next_pending;
    end
  end

endmodule : timer_match_unit

// file: random_index_unit.sv
// Random replacement index bounded below by the fixed-entry boundary
`timescale 1ns/100ps
module random_index_unit #(
  parameter int ENTRIES = 64
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       step,
  input  wire logic       reload,
  input  wire logic [5:0] lower_bound,
  output logic [5:0]      index
);

  localparam logic [5:0] UPPER = 6'(ENTRIES - 1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      index <= UPPER;
    end else if (reload) begin
      index <= UPPER;
    end else if (step) begin
      // Wrap to top once the boundary is reached so fixed entries are never chosen
      if (index <= lower_bound || index == 6'h00) begin
        index <= UPPER;
      end else begin
        index <= index - 6'h01;
      end
    end
  end

endmodule : random_index_unit

// file: tlb_support_registers.sv
// Translation support registers: context, page mask, boundary, fault address, timer, entry high
`timescale 1ns/100ps
module tlb_support_registers #(
  parameter int ENTRIES = tlb_support_pkg::TLB_ENTRIES
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // Register access port
  input  wire logic        REG_WRITE,
  input  wire logic        REG_READ,
  input  wire logic [4:0]  REG_INDEX,
  input  wire logic [63:0] REG_WDATA,
  input  wire logic        KERNEL_MODE,
  input  wire logic        COPROCESSOR_ZERO_USABLE,
  output logic [63:0]      REG_RDATA,
  output logic             REG_RVALID,
  output logic             UNUSABLE_FAULT,
  // Exception reporting
  input  wire logic        ADDR_FAULT,
  input  wire logic        TLB_MISS,
  input  wire logic        ENTRY_FAULT,
  input  wire logic [63:0] FAULT_VADDR,
  input  wire logic [7:0]  FAULT_TAG,
  input  wire logic        FAULT_HOLD,
  input  wire logic        ADDR_64BIT,
  // Translation buffer side
  input  wire logic        ENTRY_LOAD,
  input  wire logic [63:0] ENTRY_LOAD_DATA,
  input  wire logic        RANDOM_STEP,
  output logic [5:0]       RANDOM_INDEX,
  output logic [63:0]      ENTRY_HIGH,
  output logic [11:0]      PAGE_SIZE_MASK,
  output logic [23:0]      COMPARE_ENABLE,
  // Interrupt side
  input  wire logic        INTERRUPT_MASK_BIT7,
  output logic             INTERRUPT_PENDING_BIT7,
  output logic             TIMER_INTERRUPT
);

  logic        access_ok;
  logic        wr;
  logic        rd;
  logic [40:0] table_base_pointer;
  logic [18:0] faulting_page_pair_number;
  logic [11:0] page_size_mask;
  logic [5:0]  fixed_entry_boundary;
  logic [63:0] faulting_virtual_address;
  logic [1:0]  entry_region;
  logic [30:0] page_pair_number;
  logic [7:0]  address_space_tag;
  logic [31:0] count_value;
  logic [31:0] match_value;
  logic        timer_pending;
  logic        random_reload;
  logic [5:0]  random_index;
  logic [63:0] next_rdata;
  logic [63:0] entry_word;
  logic        ctx_write;
  logic        mask_write;
  logic        boundary_write;
  logic        entry_write;
  logic        count_write;
  logic        match_write;
  logic        fault_capture;
  logic        entry_capture;

  // Reset images of the registered outputs; only the random top is tied to the entry count
  localparam logic [5:0]  RANDOM_TOP  = 6'(ENTRIES - 1);
  localparam logic [23:0] ALL_COMPARE = 24'hff_ffff;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic is_write(input logic en, input logic [4:0] idx, input logic [4:0] target);
    is_write = en && (idx == target);
  endfunction : is_write

  // Address bits 24:13 that still take part in the compare, plus the fixed bits above
  function automatic logic [23:0] compare_bits(input logic [11:0] mask);
    compare_bits = {12'hfff, ~mask};
  endfunction : compare_bits

  function automatic logic mask_legal(input logic [11:0] mask);
    case (mask)
      tlb_support_pkg::MASK_4K,
      tlb_support_pkg::MASK_16K,
      tlb_support_pkg::MASK_64K,
      tlb_support_pkg::MASK_256K,
      tlb_support_pkg::MASK_1M,
      tlb_support_pkg::MASK_4M,
      tlb_support_pkg::MASK_16M: mask_legal = 1'b1;
      default:                   mask_legal = 1'b0;
    endcase
  endfunction : mask_legal

  // Gate accesses by privilege, fault otherwise
  assign access_ok = KERNEL_MODE | COPROCESSOR_ZERO_USABLE;
  assign wr        = REG_WRITE & access_ok;
  assign rd        = REG_READ & access_ok;

  // ****************************************
  // Write and capture decode
  // ****************************************
  // Strobes as plain nets so every reader follows the write enable too
  assign ctx_write      = is_write(wr, REG_INDEX, tlb_support_pkg::REG_CONTEXT_POINTER);
  assign mask_write     = is_write(wr, REG_INDEX, tlb_support_pkg::REG_PAGE_SIZE_MASK);
  assign boundary_write = is_write(wr, REG_INDEX, tlb_support_pkg::REG_FIXED_BOUNDARY);
  assign entry_write    = is_write(wr, REG_INDEX, tlb_support_pkg::REG_ENTRY_HIGH);
  assign count_write    = is_write(wr, REG_INDEX, tlb_support_pkg::REG_TIMER_COUNTER);
  assign match_write    = is_write(wr, REG_INDEX, tlb_support_pkg::REG_TIMER_MATCH);
  // Held contexts keep the old fault address
  assign fault_capture  = (TLB_MISS | ENTRY_FAULT | ADDR_FAULT) & ~FAULT_HOLD;
  assign entry_capture  = TLB_MISS | ENTRY_FAULT;

  // ****************************************
  // Context pointer
  // ****************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      table_base_pointer <= 41'h000_0000_0000;
    end else if (ctx_write) begin
      table_base_pointer <= REG_WDATA[63:tlb_support_pkg::CTX_BASE_LSB];
    end
  end

  // Pair number is hardware written only, on a miss
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      faulting_page_pair_number <= 19'h0_0000;
    end else if (TLB_MISS) begin
      faulting_page_pair_number <=
        FAULT_VADDR[tlb_support_pkg::VA_PAIR32_MSB:tlb_support_pkg::VA_PAIR_LSB];
    end
  end

  // ****************************************
  // Page size mask
  // ****************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      page_size_mask <= tlb_support_pkg::MASK_4K;
    end else if (mask_write) begin
      page_size_mask <= REG_WDATA[tlb_support_pkg::MASK_MSB:tlb_support_pkg::MASK_LSB];
    end
  end

  // ****************************************
  // Fixed entry boundary and random index
  // ****************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      fixed_entry_boundary <= tlb_support_pkg::BOUNDARY_RESET[5:0];
    end else if (boundary_write) begin
      fixed_entry_boundary <= REG_WDATA[5:0];
    end
  end

  assign random_reload = boundary_write;

  random_index_unit #(
    .ENTRIES (ENTRIES)
  ) u_random (
    .clk         (CLK),
    .rst_n       (RST_N),
    .step        (RANDOM_STEP),
    .reload      (random_reload),
    .lower_bound (fixed_entry_boundary),
    .index       (random_index)
  );

  // ****************************************
  // Faulting virtual address
  // ****************************************
  // Held through soft reset, nonmaskable interrupt and cache error
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      faulting_virtual_address <= tlb_support_pkg::ZERO64;
    end else if (fault_capture) begin
      faulting_virtual_address <= FAULT_VADDR;
    end
  end

  // ****************************************
  // Entry high
  // ****************************************
  // Narrow addressing keeps only the low word; upper pair bits stay zero
  always_comb begin
    entry_word = REG_WDATA;
    if (ENTRY_LOAD) begin
      entry_word = ENTRY_LOAD_DATA;
    end
    if (!ADDR_64BIT) begin
      entry_word[63:32] = 32'h0000_0000;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      entry_region      <= tlb_support_pkg::REGION_USER;
      page_pair_number  <= 31'h0000_0000;
      address_space_tag <= 8'h00;
    end else if (entry_capture) begin
      entry_region      <= ADDR_64BIT ?
        FAULT_VADDR[tlb_support_pkg::ENTRY_REGION_MSB:tlb_support_pkg::ENTRY_REGION_LSB] : 2'h0;
      page_pair_number  <= ADDR_64BIT ?
        FAULT_VADDR[tlb_support_pkg::ENTRY_PAIR_MSB:tlb_support_pkg::ENTRY_PAIR_LSB] :
        {12'h000, FAULT_VADDR[tlb_support_pkg::VA_PAIR32_MSB:tlb_support_pkg::VA_PAIR_LSB]};
      address_space_tag <= FAULT_TAG;
    end else if (ENTRY_LOAD || entry_write) begin
      entry_region      <= entry_word[tlb_support_pkg::ENTRY_REGION_MSB:tlb_support_pkg::ENTRY_REGION_LSB];
      page_pair_number  <= entry_word[tlb_support_pkg::ENTRY_PAIR_MSB:tlb_support_pkg::ENTRY_PAIR_LSB];
      address_space_tag <= entry_word[tlb_support_pkg::ENTRY_TAG_MSB:0];
    end
  end

  // ****************************************
  // Timer
  // ****************************************
  timer_match_unit u_timer (
    .clk         (CLK),
    .rst_n       (RST_N),
    .count_write (count_write),
    .match_write (match_write),
    .write_data  (REG_WDATA[31:0]),
    .count_value (count_value),
    .match_value (match_value),
    .pending     (timer_pending)
  );

  // ****************************************
  // Read mux
  // ****************************************
  always_comb begin
    next_rdata = tlb_support_pkg::ZERO64;
    case (REG_INDEX)
      tlb_support_pkg::REG_CONTEXT_POINTER:
        next_rdata = {table_base_pointer, faulting_page_pair_number, 4'h0};
      tlb_support_pkg::REG_PAGE_SIZE_MASK:
        next_rdata = {39'h0, page_size_mask, 13'h0000};
      tlb_support_pkg::REG_FIXED_BOUNDARY:
        next_rdata = {58'h0, fixed_entry_boundary};
      tlb_support_pkg::REG_RANDOM_INDEX:
        next_rdata = {58'h0, random_index};
      tlb_support_pkg::REG_FAULT_ADDRESS:
        next_rdata = faulting_virtual_address;
      tlb_support_pkg::REG_TIMER_COUNTER:
        next_rdata = {32'h0000_0000, count_value};
      tlb_support_pkg::REG_ENTRY_HIGH:
        next_rdata = {entry_region, 18'h0_0000, page_pair_number, 5'h00, address_space_tag};
      tlb_support_pkg::REG_TIMER_MATCH:
        next_rdata = {32'h0000_0000, match_value};
      default:
        next_rdata = tlb_support_pkg::ZERO64;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA  <= tlb_support_pkg::ZERO64;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= rd;
      if (rd) begin
        REG_RDATA <= next_rdata;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      UNUSABLE_FAULT <= 1'b0;
    end else begin
      UNUSABLE_FAULT <= (REG_WRITE | REG_READ) & ~access_ok;
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RANDOM_INDEX   <= RANDOM_TOP;
      ENTRY_HIGH     <= tlb_support_pkg::ZERO64;
      PAGE_SIZE_MASK <= tlb_support_pkg::MASK_4K;
      COMPARE_ENABLE <= ALL_COMPARE;
    end else begin
      RANDOM_INDEX   <= random_index;
      ENTRY_HIGH     <= {entry_region, 18'h0_0000, page_pair_number, 5'h00, address_space_tag};
      PAGE_SIZE_MASK <= page_size_mask;
      // Illegal masks compare every bit, a safe choice for undefined behaviour
      COMPARE_ENABLE <= mask_legal(page_size_mask) ? compare_bits(page_size_mask) : ALL_COMPARE;
    end
  end

  // Timer interrupt has no enable of its own, only the shared mask bit
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      INTERRUPT_PENDING_BIT7 <= 1'b0;
      TIMER_INTERRUPT        <= 1'b0;
    end else begin
      INTERRUPT_PENDING_BIT7 <= timer_pending;
      TIMER_INTERRUPT        <= timer_pending & INTERRUPT_MASK_BIT7;
    end
  end

endmodule : tlb_support_registers

// file: tlb_support_registers_assertions.sv
// Port-level assertions for the translation support registers
`timescale 1ns/100ps
module tlb_support_registers_assertions #(
  parameter int ENTRIES = 64
) (
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        REG_WRITE,
  input wire logic        REG_READ,
  input wire logic [4:0]  REG_INDEX,
  input wire logic        KERNEL_MODE,
  input wire logic        COPROCESSOR_ZERO_USABLE,
  input wire logic [63:0] REG_RDATA,
  input wire logic        REG_RVALID,
  input wire logic        UNUSABLE_FAULT,
  input wire logic        TLB_MISS,
  input wire logic        ENTRY_FAULT,
  input wire logic [63:0] FAULT_VADDR,
  input wire logic [7:0]  FAULT_TAG,
  input wire logic        ADDR_64BIT,
  input wire logic        ENTRY_LOAD,
  input wire logic        RANDOM_STEP,
  input wire logic [5:0]  RANDOM_INDEX,
  input wire logic [63:0] ENTRY_HIGH,
  input wire logic [11:0] PAGE_SIZE_MASK,
  input wire logic [23:0] COMPARE_ENABLE,
  input wire logic        INTERRUPT_MASK_BIT7,
  input wire logic        INTERRUPT_PENDING_BIT7,
  input wire logic        TIMER_INTERRUPT
);
  // ********
  // Helpers
  // ********
  logic priv;
  logic legal;
  logic quiet;
  assign priv  = KERNEL_MODE | COPROCESSOR_ZERO_USABLE;
  // Other patterns leave the compare undefined, so they are not judged
  assign legal = PAGE_SIZE_MASK inside {12'h000, 12'h003, 12'h00f, 12'h03f, 12'h0ff, 12'h3ff, 12'hfff};
  // Nothing else may overwrite entry high in the cycle after an event
  assign quiet = !(TLB_MISS || ENTRY_FAULT || ENTRY_LOAD || REG_WRITE);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  // ********
  // Properties
  // ********
  refused_access_a: assert property ((REG_WRITE || REG_READ) && !priv |=> UNUSABLE_FAULT)
    else $error("unprivileged access not flagged");
  read_answer_a: assert property (REG_READ && priv |=> REG_RVALID && !UNUSABLE_FAULT)
    else $error("permitted read not answered");
  valid_cause_a: assert property (REG_RVALID |-> $past(REG_READ && priv))
    else $error("read valid without a read");
  rdata_hold_a: assert property (!(REG_READ && priv) |=> $stable(REG_RDATA))
    else $error("read data moved without a read");
  mask_compare_a: assert property (legal && $stable(PAGE_SIZE_MASK) |-> COMPARE_ENABLE[11:0] == ~PAGE_SIZE_MASK)
    else $error("compare enables disagree with page size mask");
  timer_gate_a: assert property ($stable(INTERRUPT_PENDING_BIT7) && $stable(INTERRUPT_MASK_BIT7) ##1
    $stable(INTERRUPT_PENDING_BIT7) && $stable(INTERRUPT_MASK_BIT7)
    |-> TIMER_INTERRUPT == (INTERRUPT_PENDING_BIT7 && INTERRUPT_MASK_BIT7))
    else $error("timer interrupt not gated by mask bit");
  miss_load_a: assert property ((TLB_MISS || ENTRY_FAULT) && ADDR_64BIT ##1 quiet |=>
    ((ENTRY_HIGH ^ $past(FAULT_VADDR, 2)) & 64'h0000_0fff_ffff_e000) == 64'h0
    && ENTRY_HIGH[7:0] == $past(FAULT_TAG, 2))
    else $error("entry high not loaded from faulting address");
  narrow_load_a: assert property ((TLB_MISS || ENTRY_FAULT) && !ADDR_64BIT ##1 quiet |=>
    ENTRY_HIGH[63:32] == 32'h0)
    else $error("entry high upper half set in narrow mode");
  boundary_reload_a: assert property (REG_WRITE && priv && REG_INDEX == 5'h06 ##1 !RANDOM_STEP |=>
    RANDOM_INDEX == ENTRIES - 1)
    else $error("random index not reloaded by boundary write");
  fill_zero_a: assert property (ENTRY_HIGH[61:44] == 18'h0 && ENTRY_HIGH[12:8] == 5'h00)
    else $error("entry high fill or zero field set");
endmodule : tlb_support_registers_assertions

bind tlb_support_registers tlb_support_registers_assertions #(.ENTRIES(ENTRIES)) checker_inst (
  .CLK, .RST_N, .REG_WRITE, .REG_READ, .REG_INDEX, .KERNEL_MODE, .COPROCESSOR_ZERO_USABLE, .REG_RDATA,
  .REG_RVALID, .UNUSABLE_FAULT, .TLB_MISS, .ENTRY_FAULT, .FAULT_VADDR, .FAULT_TAG, .ADDR_64BIT, .ENTRY_LOAD,
  .RANDOM_STEP, .RANDOM_INDEX, .ENTRY_HIGH, .PAGE_SIZE_MASK, .COMPARE_ENABLE, .INTERRUPT_MASK_BIT7,
  .INTERRUPT_PENDING_BIT7, .TIMER_INTERRUPT
);

// file: tlb_support_registers_tb_top.sv
// Self-checking bench for the translation support registers
`timescale 1ns/100ps
module tlb_support_registers_tb_top;
  typedef struct packed {
    logic [4:0]  idx;
    logic [63:0] wd;
    logic [63:0] rexp;
  } row_t;
  logic        CLK, RST_N, REG_WRITE, REG_READ, KERNEL_MODE, COPROCESSOR_ZERO_USABLE, REG_RVALID;
  logic        UNUSABLE_FAULT, ADDR_FAULT, TLB_MISS, ENTRY_FAULT, FAULT_HOLD, ADDR_64BIT, ENTRY_LOAD;
  logic        RANDOM_STEP, INTERRUPT_MASK_BIT7, INTERRUPT_PENDING_BIT7, TIMER_INTERRUPT;
  logic [4:0]  REG_INDEX;
  logic [5:0]  RANDOM_INDEX;
  logic [7:0]  FAULT_TAG;
  logic [11:0] PAGE_SIZE_MASK;
  logic [23:0] COMPARE_ENABLE;
  logic [63:0] REG_WDATA, REG_RDATA, FAULT_VADDR, ENTRY_LOAD_DATA, ENTRY_HIGH, v, va, c0, c1;
  int          n_mismatch, total_checks, i;
  row_t        rows [7];
  logic [11:0] masks [7];

  tlb_support_registers uut (
    .CLK, .RST_N, .REG_WRITE, .REG_READ, .REG_INDEX, .REG_WDATA, .KERNEL_MODE, .COPROCESSOR_ZERO_USABLE,
    .REG_RDATA, .REG_RVALID, .UNUSABLE_FAULT, .ADDR_FAULT, .TLB_MISS, .ENTRY_FAULT, .FAULT_VADDR, .FAULT_TAG,
    .FAULT_HOLD, .ADDR_64BIT, .ENTRY_LOAD, .ENTRY_LOAD_DATA, .RANDOM_STEP, .RANDOM_INDEX, .ENTRY_HIGH,
    .PAGE_SIZE_MASK, .COMPARE_ENABLE, .INTERRUPT_MASK_BIT7, .INTERRUPT_PENDING_BIT7, .TIMER_INTERRUPT
  );

  // ********
  // Tasks
  // ********
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic access(input logic wr, input logic [4:0] idx, input logic [63:0] data);
    @(posedge CLK);
    REG_WRITE <= wr;
    REG_READ  <= !wr;
    REG_INDEX <= idx;
    REG_WDATA <= data;
    @(posedge CLK);
    REG_WRITE <= 1'b0;
    REG_READ  <= 1'b0;
  endtask : access

  task automatic rd(input logic [4:0] idx, output logic [63:0] val);
    int k;
    access(1'b0, idx, 64'h0);
    #1;
    for (k = 0; k < 4 && REG_RVALID !== 1'b1; k++) begin
      @(posedge CLK);
      #1;
    end
    if (k == 4) begin
      n_mismatch++;
      end_sim();
    end
    val = REG_RDATA;
  endtask : rd

  // Kind bits: entry load, address error, miss, entry fault
  task automatic fault(input logic [3:0] kind, input logic [63:0] addr, input logic hold);
    @(posedge CLK);
    {ENTRY_LOAD, ADDR_FAULT, TLB_MISS, ENTRY_FAULT} <= kind;
    FAULT_VADDR     <= addr;
    ENTRY_LOAD_DATA <= addr;
    FAULT_HOLD      <= hold;
    @(posedge CLK);
    {ENTRY_LOAD, ADDR_FAULT, TLB_MISS, ENTRY_FAULT} <= 4'h0;
    FAULT_HOLD <= 1'b0;
  endtask : fault

  // ********
  // Sequence
  // ********
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  initial begin
    {RST_N, REG_WRITE, REG_READ, COPROCESSOR_ZERO_USABLE, ADDR_FAULT, TLB_MISS} = 6'h00;
    {ENTRY_FAULT, FAULT_HOLD, ENTRY_LOAD, RANDOM_STEP} = 4'h0;
    {KERNEL_MODE, ADDR_64BIT, INTERRUPT_MASK_BIT7} = 3'h7;
    REG_INDEX = 5'h00;
    {REG_WDATA, FAULT_VADDR, ENTRY_LOAD_DATA} = '0;
    FAULT_TAG = 8'h5a;
    n_mismatch = 0;
    total_checks = 0;
    rows = '{'{5'h04, 64'hffff_ffff_ff80_0000, 64'hffff_ffff_ff80_0000},
             '{5'h06, 64'h0000_0000_0000_002a, 64'h0000_0000_0000_002a},
             '{5'h01, 64'h0000_0000_0000_0005, 64'h0000_0000_0000_003f},
             '{5'h0b, 64'h0000_0000_dead_beef, 64'h0000_0000_dead_beef},
             '{5'h0a, 64'hffff_ffff_ffff_e0ff, 64'hc000_0fff_ffff_e0ff},
             '{5'h0a, 64'h4000_0000_0000_2033, 64'h4000_0000_0000_2033},
             '{5'h08, 64'h0000_0000_0000_1234, 64'h0}};
    masks = '{12'h000, 12'h003, 12'h00f, 12'h03f, 12'h0ff, 12'h3ff, 12'hfff};
    repeat (20) @(posedge CLK);
    RST_N <= 1'b1;
    foreach (rows[r]) begin
      access(1'b1, rows[r].idx, rows[r].wd);
      rd(rows[r].idx, v);
      check(v, rows[r].rexp);
    end
    foreach (masks[m]) begin
      v = {39'h0, masks[m], 13'h0000};
      access(1'b1, 5'h05, v);
      rd(5'h05, c0);
      check(c0, v);
      check({52'h0, PAGE_SIZE_MASK}, {52'h0, masks[m]});
      check({40'h0, COMPARE_ENABLE}, {40'h0, 12'hfff, ~masks[m]});
    end
    $display("test register rows done");
    va = 64'hc000_0abc_dea5_7123;
    fault(4'h2, va, 1'b0);
    rd(5'h04, v);
    check(v, {rows[0].wd[63:23], va[31:13], 4'h0});
    rd(5'h08, v);
    check(v, va);
    rd(5'h0a, v);
    check(v & 64'h0000_0fff_ffff_e0ff, {20'h0, va[43:13], 5'h00, 8'h5a});
    fault(4'h4, ~va, 1'b1);
    rd(5'h08, v);
    check(v, va);
    fault(4'h4, ~va, 1'b0);
    rd(5'h08, v);
    check(v, ~va);
    ADDR_64BIT <= 1'b0;
    fault(4'h1, va, 1'b0);
    rd(5'h0a, v);
    check(v & 64'hffff_ffff_ffff_e0ff, {32'h0, va[31:13], 5'h00, 8'h5a});
    ADDR_64BIT <= 1'b1;
    fault(4'h8, 64'h4000_0000_0000_4033, 1'b0);
    rd(5'h0a, v);
    check(v, 64'h4000_0000_0000_4033);
    check(ENTRY_HIGH, 64'h4000_0000_0000_4033);
    $display("test fault capture done");
    KERNEL_MODE <= 1'b0;
    access(1'b1, 5'h06, 64'h0000_0000_0000_0003);
    #1;
    check({63'h0, UNUSABLE_FAULT}, 64'h1);
    COPROCESSOR_ZERO_USABLE <= 1'b1;
    rd(5'h06, v);
    check(v, rows[1].wd);
    KERNEL_MODE <= 1'b1;
    for (i = 0; i < 30; i++) begin
      @(posedge CLK);
      RANDOM_STEP <= 1'b1;
      #1;
      check({63'h0, RANDOM_INDEX >= 6'h2a}, 64'h1);
    end
    RANDOM_STEP <= 1'b0;
    access(1'b1, 5'h06, 64'h0000_0000_0000_002a);
    rd(5'h01, v);
    check(v, 64'h0000_0000_0000_003f);
    $display("test privilege and random done");
    access(1'b1, 5'h09, 64'h0000_0000_ffff_fff0);
    rd(5'h09, c0);
    repeat (38) @(posedge CLK);
    rd(5'h09, c1);
    check({32'h0, c1[31:0] - c0[31:0]}, 64'h14);
    check({63'h0, c1[31:0] < 32'h0000_0020}, 64'h1);
    access(1'b1, 5'h0b, {32'h0, c1[31:0] + 32'h0000_0040});
    for (i = 0; i < 200 && INTERRUPT_PENDING_BIT7 !== 1'b1; i++) begin
      @(posedge CLK);
      #1;
    end
    check({63'h0, i > 100 && i < 200}, 64'h1);
    if (i == 200) begin
      end_sim();
    end
    repeat (2) @(posedge CLK);
    #1;
    check({63'h0, TIMER_INTERRUPT}, 64'h1);
    INTERRUPT_MASK_BIT7 <= 1'b0;
    repeat (3) @(posedge CLK);
    #1;
    check({62'h0, TIMER_INTERRUPT, INTERRUPT_PENDING_BIT7}, 64'h1);
    access(1'b1, 5'h0b, {32'h0, c1[31:0]});
    repeat (3) @(posedge CLK);
    #1;
    check({63'h0, INTERRUPT_PENDING_BIT7}, 64'h0);
    $display("test timer done");
    @(posedge CLK);
    RST_N <= 1'b0;
    repeat (3) @(posedge CLK);
    RST_N <= 1'b1;
    rd(5'h06, v);
    check(v, 64'h0);
    check({58'h0, RANDOM_INDEX}, 64'h3f);
    $display("test second reset done");
    end_sim();
  end
endmodule : tlb_support_registers_tb_top
